// ===== design/dma_remap_fault_check.sv
// Fault check and blocking stage of the address remapping unit.
// Assumes the page walk has already resolved every status input
// presented with a request, and an APB master for the registers.
`timescale 1ns/1ps
`default_nettype none
module dma_remap_fault_check #(
  parameter int         MAX_GUEST_WIDTH = 48,
  parameter logic [4:0] AW_SUPPORTED    = 5'h04,
  parameter logic [3:0] TT_SUPPORTED    = 4'h1,
  parameter int         WALK_LEVELS     = 4
) (
  input  wire logic                   clk,
  input  wire logic                   reset,
  input  wire logic                   psel,
  input  wire logic                   penable,
  input  wire logic                   pwrite,
  input  wire logic [7:0]             paddr,
  input  wire logic [31:0]            pwdata,
  output logic                        pready,
  output logic      [31:0]            prdata,
  output logic                        pslverr,
  input  wire logic                   req_valid,
  output logic                        req_ready,
  input  wire logic [63:0]            req_addr,
  input  wire logic [1:0]             req_at,
  input  wire logic                   req_write,
  input  wire logic                   req_atomic,
  input  wire logic                   req_pcie,
  input  wire logic                   req_zero_len,
  input  wire logic                   req_fatal_err,
  input  wire logic                   root_table_base_err,
  input  wire logic                   root_present,
  input  wire logic                   root_rsvd_nz,
  input  wire logic                   ctx_table_pointer_err,
  input  wire logic                   ctx_present,
  input  wire logic                   ctx_rsvd_nz,
  input  wire logic [2:0]             domain_width_field,
  input  wire logic [1:0]             ctx_tt,
  input  wire logic                   table_root_pointer_err,
  input  wire logic                   fault_report_disable,
  input  wire logic                   pte_fetch_err,
  input  wire logic [WALK_LEVELS-1:0] walk_read,
  input  wire logic [WALK_LEVELS-1:0] walk_write,
  input  wire logic [WALK_LEVELS-1:0] walk_used,
  input  wire logic                   pte_rsvd_nz,
  output logic                        pass_valid,
  input  wire logic                   pass_ready,
  output logic      [63:0]            pass_addr,
  output logic                        pass_write,
  output logic                        cpl_valid,
  input  wire logic                   cpl_ready,
  output logic      [2:0]             cpl_status,
  output logic                        cpl_pcie,
  output logic                        fault_valid,
  output logic      [3:0]             fault_reason,
  output logic                        fault_qualified,
  output logic                        fault_report,
  output logic                        err_nonfatal,
  output logic                        aer_range,
  output logic                        hw_error,
  output logic                        cache_fill,
  output logic                        cache_read,
  output logic                        cache_write
);
  // ==========================================================
  // Elaboration checks
  if (MAX_GUEST_WIDTH < 30 || MAX_GUEST_WIDTH > 64 || WALK_LEVELS < 1 || WALK_LEVELS > 6) begin : g_bad
    $error("dma_remap_fault_check: unsupported parameter value");
  end

  localparam logic [6:0] MGW_RST = 7'(MAX_GUEST_WIDTH);

  // ==========================================================
  // Registers and state
  logic [2:0]  ctrl_flags;
  logic [6:0]  mgw;
  logic [3:0]  last_reason;
  logic        last_qual;
  logic        fault_seen;
  logic [31:0] fault_cnt;
  logic [31:0] pass_cnt;
  remap_pkg::stage_e state;
  remap_pkg::stage_e next_state;

  logic        accept;
  logic        checked;
  logic [3:0]  cls_reason;
  logic        cls_qual;
  logic        blocked;
  logic        stage_done;
  logic        apb_wr;
  logic        apb_rd;
  logic        perm_r;
  logic        perm_w;

  // Clamp software width to the hardware maximum
  fault_classify u_classify (
    .addr                   (req_addr),
    .is_write               (req_write),
    .is_atomic              (req_atomic),
    .zero_len               (req_zero_len),
    .zero_len_read_support  (ctrl_flags[remap_pkg::CTRL_ZLR]),
    .max_guest_width        (mgw > MGW_RST ? MGW_RST : mgw),
    .aw_supported           (AW_SUPPORTED),
    .tt_supported           (TT_SUPPORTED),
    .root_table_base_err    (root_table_base_err),
    .root_present           (root_present),
    .root_rsvd_nz           (root_rsvd_nz),
    .ctx_table_pointer_err  (ctx_table_pointer_err),
    .ctx_present            (ctx_present),
    .ctx_rsvd_nz            (ctx_rsvd_nz),
    .domain_width_field     (domain_width_field),
    .ctx_tt                 (ctx_tt),
    .table_root_pointer_err (table_root_pointer_err),
    .pte_fetch_err          (pte_fetch_err),
    .pte_read               (perm_r),
    .pte_write              (perm_w),
    .pte_rsvd_nz            (pte_rsvd_nz),
    .reason                 (cls_reason),
    .qualified              (cls_qual)
  );

  // ==========================================================
  // Request decision
  // Effective permissions: unused levels do not restrict
  assign perm_r     = &(walk_read | ~walk_used);
  assign perm_w     = &(walk_write | ~walk_used);
  assign checked    = (req_at == remap_pkg::AT_UNTRANSLATED);
  assign blocked    = checked && (cls_reason != remap_pkg::FR_NONE);
  assign stage_done = (state == remap_pkg::ST_IDLE)
                   || (state == remap_pkg::ST_PASS && pass_ready)
                   || (state == remap_pkg::ST_CPL && cpl_ready);
  assign req_ready  = stage_done;
  assign accept     = req_valid && req_ready;

  // Stage state: faulting writes never leave idle, so they vanish
  always_comb begin
    next_state = state;
    case (state)
      remap_pkg::ST_IDLE, remap_pkg::ST_PASS, remap_pkg::ST_CPL: begin
        if (stage_done)
          next_state = remap_pkg::ST_IDLE;
        if (accept && req_fatal_err)
          next_state = req_write ? remap_pkg::ST_IDLE : remap_pkg::ST_CPL;
        else if (accept && !blocked)
          next_state = remap_pkg::ST_PASS;
        else if (accept && !req_write)
          next_state = remap_pkg::ST_CPL;
        else if (accept)
          next_state = remap_pkg::ST_IDLE;
      end
      default: next_state = remap_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (reset)
      state <= remap_pkg::ST_IDLE;
    else
      state <= next_state;
  end

  // Forwarded request payload
  always_ff @(posedge clk) begin
    if (reset) begin
      pass_addr  <= 64'h0;
      pass_write <= 1'b0;
      cpl_pcie   <= 1'b0;
    end else if (accept) begin
      pass_addr  <= req_addr;
      pass_write <= req_write;
      cpl_pcie   <= req_pcie;
    end
  end

  assign pass_valid = (state == remap_pkg::ST_PASS);
  assign cpl_valid  = (state == remap_pkg::ST_CPL);
  // Any error completion reports Unsupported Request; no data returned
  assign cpl_status = remap_pkg::CPL_UNSUPPORTED;

  // ==========================================================
  // Fault and error outputs, one pulse in the cycle after acceptance
  always_ff @(posedge clk) begin
    if (reset) begin
      fault_valid     <= 1'b0;
      fault_reason    <= remap_pkg::FR_NONE;
      fault_qualified <= 1'b0;
      fault_report    <= 1'b0;
      hw_error        <= 1'b0;
      aer_range       <= 1'b0;
    end else begin
      fault_valid     <= accept && blocked && !req_fatal_err;
      fault_reason    <= accept ? cls_reason : remap_pkg::FR_NONE;
      fault_qualified <= accept && cls_qual;
      fault_report    <= accept && blocked && !req_fatal_err
                         && !(cls_qual && fault_report_disable);
      hw_error        <= accept && req_fatal_err;
      aer_range       <= accept && blocked && !req_fatal_err && req_pcie
                         && cls_reason == remap_pkg::FR_ADDR_RANGE
                         && ctrl_flags[remap_pkg::CTRL_AER];
    end
  end

  // Non-fatal message goes out the cycle after a PCIe error completion leaves
  always_ff @(posedge clk) begin
    if (reset)
      err_nonfatal <= 1'b0;
    else
      err_nonfatal <= cpl_valid && cpl_ready && cpl_pcie
                      && ctrl_flags[remap_pkg::CTRL_NONFATAL];
  end

  // Translation cache fill for successful untranslated walks
  always_ff @(posedge clk) begin
    if (reset) begin
      cache_fill  <= 1'b0;
      cache_read  <= 1'b0;
      cache_write <= 1'b0;
    end else begin
      cache_fill  <= accept && checked && !blocked && !req_fatal_err;
      cache_read  <= perm_r;
      cache_write <= perm_w;
    end
  end

  // ==========================================================
  // APB slave, zero wait states
  assign apb_wr  = psel && penable && pwrite;
  assign apb_rd  = psel && penable && !pwrite;
  assign pready  = 1'b1;
  assign pslverr = psel && penable && (paddr > remap_pkg::PASS_CNT_OFS || paddr[1:0] != 2'b00);

  always_ff @(posedge clk) begin
    if (reset) begin
      ctrl_flags <= remap_pkg::CTRL_FLAGS_RST;
      mgw        <= MGW_RST;
    end else if (apb_wr && paddr == remap_pkg::CTRL_OFS) begin
      ctrl_flags <= pwdata[2:0];
      mgw        <= pwdata[remap_pkg::CTRL_MGW_LSB +: 7];
    end
  end

  // Last fault snapshot; a new fault wins over a software clear
  always_ff @(posedge clk) begin
    if (reset) begin
      last_reason <= remap_pkg::FR_NONE;
      last_qual   <= 1'b0;
      fault_seen  <= 1'b0;
    end else if (fault_valid) begin
      last_reason <= fault_reason;
      last_qual   <= fault_qualified;
      fault_seen  <= 1'b1;
    end else if (apb_wr && paddr == remap_pkg::STATUS_OFS && pwdata[remap_pkg::STAT_SEEN]) begin
      fault_seen  <= 1'b0;
    end
  end

  // Counters clear on a write to their own offset; a same-cycle event still counts
  always_ff @(posedge clk) begin
    if (reset) begin
      fault_cnt <= 32'h0;
      pass_cnt  <= 32'h0;
    end else begin
      if (apb_wr && paddr == remap_pkg::FAULT_CNT_OFS)
        fault_cnt <= {31'h0, fault_valid};
      else if (fault_valid)
        fault_cnt <= fault_cnt + 32'h1;
      if (apb_wr && paddr == remap_pkg::PASS_CNT_OFS)
        pass_cnt <= {31'h0, pass_valid && pass_ready};
      else if (pass_valid && pass_ready)
        pass_cnt <= pass_cnt + 32'h1;
    end
  end

  always_comb begin
    prdata = 32'h0;
    if (apb_rd) begin
      case (paddr)
        remap_pkg::CTRL_OFS:      prdata = {17'h0, mgw, 5'h0, ctrl_flags};
        remap_pkg::STATUS_OFS:    prdata = {23'h0, fault_seen, 3'h0, last_qual, last_reason};
        remap_pkg::FAULT_CNT_OFS: prdata = fault_cnt;
        remap_pkg::PASS_CNT_OFS:  prdata = pass_cnt;
        default:                  prdata = 32'h0;
      endcase
    end
  end

  // ==========================================================
  // Assertions
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  block_no_pass_a: assert property (accept && blocked |=> !pass_valid)
    else $error("blocked request was forwarded");
  write_drop_a: assert property (accept && blocked && req_write |=> state == remap_pkg::ST_IDLE)
    else $error("blocked write not dropped");
  read_cpl_a: assert property (accept && blocked && !req_write && !req_fatal_err |=> cpl_valid && cpl_status == remap_pkg::CPL_UNSUPPORTED)
    else $error("blocked read without error completion");
  nonfatal_msg_a: assert property (cpl_valid && cpl_ready && cpl_pcie && ctrl_flags[0] |=> err_nonfatal)
    else $error("no non-fatal message after error completion");
  translated_skip_a: assert property (accept && req_at != 2'b00 && !req_fatal_err |=> !fault_valid)
    else $error("translated request faulted");
  root_absent_a: assert property (accept && checked && !req_fatal_err && root_present == 1'b0 && !root_table_base_err |=> fault_reason == 4'h1 && !fault_qualified)
    else $error("root absent reason wrong");
  range_reason_a: assert property (fault_valid && fault_reason == 4'h4 |-> fault_qualified)
    else $error("range fault not qualified");
  report_gate_a: assert property (fault_valid && fault_qualified && $past(fault_report_disable) |-> !fault_report)
    else $error("disabled qualified fault reported");
  hold_cpl_a: assert property (cpl_valid && !cpl_ready |=> cpl_valid)
    else $error("error completion withdrawn");
  fatal_path_a: assert property (accept && req_fatal_err |=> hw_error && !fault_valid)
    else $error("fatal error routed as fault");
  // Back-to-back fatal requests may hold the pulse, so tie each pulse to its cause
  fatal_pulse_a: assert property (hw_error |-> $past(accept && req_fatal_err))
    else $error("hardware error without a fatal request");
  cache_and_a: assert property (cache_fill |-> cache_read == $past((walk_read & walk_used) == walk_used)
                                && cache_write == $past((walk_write & walk_used) == walk_used))
    else $error("cached permission not the walk AND");

  pass_seen_c:  cover property (accept && !blocked ##1 pass_valid && pass_ready);
  read_ur_c:    cover property (cpl_valid && cpl_ready && cpl_pcie);
  qual_gate_c:  cover property (fault_valid && fault_qualified && !fault_report);
  back_to_back_c: cover property (fault_valid [*2]);
endmodule
`default_nettype wire

// ===== design/remap_pkg.sv
// Shared constants for the remapping fault check block.
// Assumes one 200 MHz clock and an APB register port.
package remap_pkg;
  // ==========================================================
  // Fault reason codes
  localparam logic [3:0] FR_NONE         = 4'h0;
  localparam logic [3:0] FR_ROOT_ABSENT  = 4'h1;
  localparam logic [3:0] FR_CTX_ABSENT   = 4'h2;
  localparam logic [3:0] FR_CTX_INVALID  = 4'h3;
  localparam logic [3:0] FR_ADDR_RANGE   = 4'h4;
  localparam logic [3:0] FR_NO_WRITE     = 4'h5;
  localparam logic [3:0] FR_NO_READ      = 4'h6;
  localparam logic [3:0] FR_PTE_FETCH    = 4'h7;
  localparam logic [3:0] FR_ROOT_FETCH   = 4'h8;
  localparam logic [3:0] FR_CTX_FETCH    = 4'h9;
  localparam logic [3:0] FR_ROOT_RSVD    = 4'ha;
  localparam logic [3:0] FR_CTX_RSVD     = 4'hb;
  localparam logic [3:0] FR_PTE_RSVD     = 4'hc;
  // ==========================================================
  // Request, completion and address width encodings
  localparam logic [1:0] AT_UNTRANSLATED = 2'b00;
  localparam logic [2:0] CPL_SUCCESS     = 3'h0;
  localparam logic [2:0] CPL_UNSUPPORTED = 3'h1;
  localparam logic [6:0] AGAW_BASE       = 7'h1e;
  localparam logic [6:0] AGAW_STEP       = 7'h09;
  localparam logic [6:0] ADDR_BITS_MAX   = 7'h40;
  // ==========================================================
  // Register map
  localparam logic [7:0] CTRL_OFS        = 8'h00;
  localparam logic [7:0] STATUS_OFS      = 8'h04;
  localparam logic [7:0] FAULT_CNT_OFS   = 8'h08;
  localparam logic [7:0] PASS_CNT_OFS    = 8'h0c;
  localparam int         CTRL_NONFATAL   = 0;
  localparam int         CTRL_AER        = 1;
  localparam int         CTRL_ZLR        = 2;
  localparam int         CTRL_MGW_LSB    = 8;
  localparam int         STAT_QUAL       = 4;
  localparam int         STAT_SEEN       = 8;
  localparam logic [2:0] CTRL_FLAGS_RST  = 3'h5;
  // ==========================================================
  // Decision stage states
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_PASS = 3'b010,
    ST_CPL  = 3'b100
  } stage_e;
endpackage

// ===== design/fault_classify.sv
// Combinational fault classifier for one untranslated request.
// Assumes walk status inputs are valid with the request.
`timescale 1ns/1ps
`default_nettype none
module fault_classify (
  input  wire logic [63:0] addr,
  input  wire logic        is_write,
  input  wire logic        is_atomic,
  input  wire logic        zero_len,
  input  wire logic        zero_len_read_support,
  input  wire logic [6:0]  max_guest_width,
  input  wire logic [4:0]  aw_supported,
  input  wire logic [3:0]  tt_supported,
  input  wire logic        root_table_base_err,
  input  wire logic        root_present,
  input  wire logic        root_rsvd_nz,
  input  wire logic        ctx_table_pointer_err,
  input  wire logic        ctx_present,
  input  wire logic        ctx_rsvd_nz,
  input  wire logic [2:0]  domain_width_field,
  input  wire logic [1:0]  ctx_tt,
  input  wire logic        table_root_pointer_err,
  input  wire logic        pte_fetch_err,
  input  wire logic        pte_read,
  input  wire logic        pte_write,
  input  wire logic        pte_rsvd_nz,
  output logic      [3:0]  reason,
  output logic             qualified
);
  // ==========================================================
  // Helpers
  function automatic logic [6:0] agaw_of(input logic [2:0] w);
    agaw_of = remap_pkg::AGAW_BASE + 7'(w) * remap_pkg::AGAW_STEP;
    if (agaw_of > remap_pkg::ADDR_BITS_MAX)
      agaw_of = remap_pkg::ADDR_BITS_MAX;
  endfunction

  function automatic logic above_width(input logic [63:0] a, input logic [6:0] x);
    above_width = (x >= remap_pkg::ADDR_BITS_MAX) ? 1'b0 : |(a >> x);
  endfunction

  logic [6:0] dom_bits;
  logic [6:0] lim_bits;
  logic       aw_bad;
  logic       is_read;
  assign dom_bits = agaw_of(domain_width_field);
  assign lim_bits = (dom_bits < max_guest_width) ? dom_bits : max_guest_width;
  assign aw_bad   = (domain_width_field > 3'h4) || !aw_supported[domain_width_field];
  assign is_read  = !is_write;

  // ==========================================================
  // Walk order decides priority: earliest structure faults first
  always_comb begin
    reason    = remap_pkg::FR_NONE;
    qualified = 1'b0;
    if (root_table_base_err) begin
      reason = remap_pkg::FR_ROOT_FETCH;
    end else if (!root_present) begin
      reason = remap_pkg::FR_ROOT_ABSENT;
    end else if (root_rsvd_nz) begin
      reason = remap_pkg::FR_ROOT_RSVD;
    end else if (ctx_table_pointer_err) begin
      reason = remap_pkg::FR_CTX_FETCH;
    end else if (!ctx_present) begin
      reason    = remap_pkg::FR_CTX_ABSENT;
      qualified = 1'b1;
    end else if (ctx_rsvd_nz) begin
      reason    = remap_pkg::FR_CTX_RSVD;
      qualified = 1'b1;
    end else if (aw_bad || !tt_supported[ctx_tt] || table_root_pointer_err) begin
      reason    = remap_pkg::FR_CTX_INVALID;
      qualified = 1'b1;
    end else if (above_width(addr, lim_bits)) begin
      reason    = remap_pkg::FR_ADDR_RANGE;
      qualified = 1'b1;
    end else if (pte_fetch_err) begin
      reason    = remap_pkg::FR_PTE_FETCH;
      qualified = 1'b1;
    end else if (pte_rsvd_nz && (pte_read || pte_write)) begin
      reason    = remap_pkg::FR_PTE_RSVD;
      qualified = 1'b1;
    end else if ((is_write || is_atomic) && !pte_write) begin
      reason    = remap_pkg::FR_NO_WRITE;
      qualified = 1'b1;
    end else if ((is_read || is_atomic) && !pte_read
                 && !(zero_len && zero_len_read_support && !is_atomic && pte_write)) begin
      reason    = remap_pkg::FR_NO_READ;
      qualified = 1'b1;
    end
  end
endmodule
`default_nettype wire

// ===== bench/req_sink.sv
// Far-side sink for forwarded requests and error completions.
// Assumes the bench drives stall by non-blocking assignment.
`timescale 1ns/1ps
`default_nettype none
module req_sink (
  input  wire logic stall,
  input  wire logic pass_valid,
  input  wire logic cpl_valid,
  output logic      pass_ready,
  output logic      cpl_ready
);
  // ==========================================================
  // Ready only when offered; stall models a slow memory side
  assign pass_ready = pass_valid & ~stall;
  assign cpl_ready  = cpl_valid & ~stall;
endmodule
`default_nettype wire

// ===== bench/testbench.sv
// Self-checking bench for the remap fault check block.
// Assumes a 200 MHz clock and the default build parameters.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic        clk = 0, reset = 1, psel = 0, penable = 0, pwrite = 0, pready, pslverr, stall = 0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata;
  logic [63:0] req_addr = 64'h0, pass_addr;
  logic [14:0] bad = 15'h0;
  logic [1:0]  req_at = 2'b00;
  logic [1:0]  ctx_tt = 2'b00;
  logic [2:0]  dom_w = 3'h2;
  logic        req_fatal_err = 0;
  localparam logic [2:0] CPLUR = remap_pkg::CPL_UNSUPPORTED;
  logic [3:0]  fault_reason;
  logic [2:0]  cpl_status;
  logic        req_valid = 0, req_write = 0, req_ready, pass_valid, pass_ready, pass_write, cpl_valid, cpl_ready;
  logic        cpl_pcie, fault_valid, fault_qualified, fault_report, err_nonfatal, aer_range, hw_error;
  logic        cache_fill, cache_read, cache_write;
  int          miscompares = 0, checks = 0;
  // ==========================================================
  // Clock, design and far side
  always #2.5 clk = ~clk;
  dma_remap_fault_check dut (.clk(clk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr), .req_valid(req_valid),
    .req_ready(req_ready), .req_addr(req_addr), .req_at(req_at), .req_write(req_write), .req_atomic(bad[9]),
    .req_pcie(~bad[10]), .req_zero_len(bad[13]), .req_fatal_err(req_fatal_err), .root_table_base_err(bad[0]),
    .root_present(~bad[1]), .root_rsvd_nz(bad[2]), .ctx_table_pointer_err(bad[3]), .ctx_present(~bad[4]),
    .ctx_rsvd_nz(bad[5]), .domain_width_field(dom_w), .ctx_tt(ctx_tt), .table_root_pointer_err(bad[6]),
    .fault_report_disable(bad[14]), .pte_fetch_err(bad[7]), .walk_read(bad[11] ? 4'he : 4'hf),
    .walk_write(bad[12] ? 4'hb : 4'hf), .walk_used(4'hf), .pte_rsvd_nz(bad[8]), .pass_valid(pass_valid),
    .pass_ready(pass_ready), .pass_addr(pass_addr), .pass_write(pass_write), .cpl_valid(cpl_valid),
    .cpl_ready(cpl_ready), .cpl_status(cpl_status), .cpl_pcie(cpl_pcie), .fault_valid(fault_valid),
    .fault_reason(fault_reason), .fault_qualified(fault_qualified), .fault_report(fault_report),
    .err_nonfatal(err_nonfatal), .aer_range(aer_range), .hw_error(hw_error), .cache_fill(cache_fill),
    .cache_read(cache_read), .cache_write(cache_write));
  req_sink sink (.stall(stall), .pass_valid(pass_valid), .cpl_valid(cpl_valid), .pass_ready(pass_ready),
    .cpl_ready(cpl_ready));
  // ==========================================================
  // Shared tasks
  task automatic chk(input logic [63:0] seen, input logic [63:0] exp, input string nm);
    checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // One APB transfer; request held until pready is seen high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [31:0] e, input logic se);
    @(posedge clk);
    psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    if (!w) chk(prdata, e, "prdata");
    chk(pslverr, se, "pslverr");
    psel <= 1'b0; penable <= 1'b0;
  endtask
  // One request with injected walk conditions, judged in the answer cycle and the one after
  task automatic rq(input logic [14:0] b, input logic [63:0] a, input logic w, input logic [3:0] er);
    logic q;
    q = !(er inside {4'h1, 4'h8, 4'h9, 4'ha});
    @(posedge clk);
    bad <= b;
    req_addr <= a;
    req_write <= w;
    req_valid <= 1'b1;
    do @(posedge clk); while (req_ready !== 1'b1);
    req_valid <= 1'b0;
    #1;
    chk(fault_valid, er != 4'h0, "fault_valid");
    if (er != 4'h0) chk({fault_reason, fault_qualified}, {er, q}, "fault_reason");
    chk(fault_report, er != 4'h0 && !(q && b[14]), "fault_report");
    chk(pass_valid, er == 4'h0, "pass_valid");
    chk(cpl_valid, er != 4'h0 && !w, "cpl_valid");
    if (cpl_valid === 1'b1) chk({cpl_status, cpl_pcie}, {CPLUR, ~b[10]}, "cpl_status");
    if (pass_valid === 1'b1) chk({pass_addr, pass_write, cache_read, cache_write}, {a, w, ~b[11], ~b[12]}, "pass");
    chk(aer_range, er == 4'h4 && !b[10], "aer_range");
    chk(cache_fill, er == 4'h0, "cache_fill");
    chk(hw_error, 1'b0, "hw_error");
    @(posedge clk);
    #1;
    chk(err_nonfatal, er != 4'h0 && !w && !b[10], "err_nonfatal");
  endtask
  // Translated request passes unchecked; a fatal error blocks with no fault pulse
  task automatic rq_side(input logic [1:0] at, input logic fe, input logic [14:0] b, input logic w);
    @(posedge clk);
    bad <= b;
    req_at <= at;
    req_fatal_err <= fe;
    req_write <= w;
    req_valid <= 1'b1;
    do @(posedge clk); while (req_ready !== 1'b1);
    req_valid <= 1'b0;
    req_at <= 2'b00;
    req_fatal_err <= 1'b0;
    #1;
    chk(fault_valid, 1'b0, "fault_valid");
    chk(hw_error, fe, "hw_error");
    chk(pass_valid, !fe, "pass_valid");
    chk(cpl_valid, fe && !w, "cpl_valid");
    chk(cache_fill, 1'b0, "cache_fill");
    @(posedge clk);
    #1;
    chk(hw_error, 1'b0, "hw_error");
  endtask
  task automatic print_verdict();
    if (miscompares == 0 && checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // ==========================================================
  // Main sequence and watchdog
  initial begin
    #50000;
    miscompares++;
    print_verdict();
  end
  initial begin
    repeat (6) @(posedge clk);
    reset <= 1'b0;
    apb(1'b0, 8'h00, 32'h0, 32'h00003005, 1'b0);
    apb(1'b0, 8'h10, 32'h0, 32'h0, 1'b1);
    apb(1'b1, 8'h00, 32'h00003007, 32'h0, 1'b0);
    rq(15'h0000, 64'h1000, 1'b0, 4'h0);
    rq(15'h0001, 64'h1000, 1'b0, 4'h8);
    rq(15'h0003, 64'h1000, 1'b1, 4'h8);
    rq(15'h0002, 64'h1000, 1'b0, 4'h1);
    rq(15'h0004, 64'h1000, 1'b0, 4'ha);
    rq(15'h0008, 64'h1000, 1'b1, 4'h9);
    rq(15'h4010, 64'h1000, 1'b0, 4'h2);
    rq(15'h0020, 64'h1000, 1'b0, 4'hb);
    rq(15'h0040, 64'h1000, 1'b0, 4'h3);
    rq(15'h0000, 64'h0001_0000_0000_0000, 1'b0, 4'h4);
    rq(15'h0000, 64'h0000_ffff_ffff_fff8, 1'b1, 4'h0);
    rq(15'h0080, 64'h1000, 1'b0, 4'h7);
    rq(15'h1100, 64'h1000, 1'b1, 4'hc);
    rq(15'h1000, 64'h1000, 1'b1, 4'h5);
    rq(15'h1200, 64'h1000, 1'b0, 4'h5);
    rq(15'h0800, 64'h1000, 1'b0, 4'h6);
    rq(15'h2800, 64'h1000, 1'b0, 4'h0);
    rq(15'h0800, 64'h1000, 1'b1, 4'h0);
    dom_w <= 3'h1;
    rq(15'h0000, 64'h1000, 1'b0, 4'h3);
    dom_w <= 3'h2;
    ctx_tt <= 2'b01;
    rq(15'h0000, 64'h1000, 1'b1, 4'h3);
    ctx_tt <= 2'b00;
    rq_side(2'b01, 1'b0, 15'h0002, 1'b0);
    rq_side(2'b00, 1'b1, 15'h0000, 1'b1);
    rq_side(2'b00, 1'b1, 15'h0000, 1'b0);
    stall <= 1'b1;
    rq(15'h0000, 64'h2000, 1'b1, 4'h0);
    chk(req_ready, 1'b0, "req_ready");
    stall <= 1'b0;
    rq(15'h0402, 64'h1000, 1'b0, 4'h1);
    apb(1'b0, 8'h04, 32'h0, 32'h00000101, 1'b0);
    apb(1'b1, 8'h04, 32'h00000100, 32'h0, 1'b0);
    apb(1'b0, 8'h04, 32'h0, 32'h00000001, 1'b0);
    apb(1'b0, 8'h08, 32'h0, 32'h00000011, 1'b0);
    apb(1'b0, 8'h0c, 32'h0, 32'h00000006, 1'b0);
    print_verdict();
  end
endmodule
`default_nettype wire
